// file: common/fts_pkg.sv
// shared constants and types for the flow-through sram pin controller
package fts_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int ADDR_W    = 18;
   localparam int DATA_W    = 16;
   localparam int PAR_W     = 2;
   localparam int WORD_W    = DATA_W + PAR_W;
   localparam int LANE_W    = 8;
   localparam int CNT_W     = 2;
   localparam int BUF_DEPTH = 2;
   localparam int APB_AW    = 12;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [APB_AW-1:0] OFS_CTRL     = 12'h000;
   localparam logic [APB_AW-1:0] OFS_STATUS   = 12'h004;
   localparam logic [APB_AW-1:0] OFS_CAPTURE  = 12'h008;
   localparam logic [APB_AW-1:0] OFS_BUF_ADDR = 12'h00C;
   localparam logic [APB_AW-1:0] OFS_BUF_DATA = 12'h010;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CTRL_EN_BIT   = 0;
   localparam int ST_MODE_BIT   = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_READ_BIT   = 2;
   localparam int ST_FIRST_BIT  = 3;
   localparam int ST_CNT_LSB    = 4;
   localparam int ST_BUF_BIT    = 6;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic MODE_RST    = 1'b1;
   // ****************************************
   // data phase state
   // ****************************************
   typedef enum logic [1:0] {
      PH_DESEL = 2'b00,
      PH_READ  = 2'b01,
      PH_WRITE = 2'b11
   } fts_phase_t;
endpackage

// file: common/fts_mem_if.sv
// carrier between the pin controller and its storage array
`timescale 1ns/1ps
interface fts_mem_if #(
   parameter int AW = 18,
   parameter int DW = 18
);
   logic          we;
   logic          re;
   logic [AW-1:0] waddr;
   logic [AW-1:0] raddr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] wmask;
   logic [DW-1:0] rdata;
   modport ctrl (output we, re, waddr, raddr, wdata, wmask, input rdata);
   modport mem  (input we, re, waddr, raddr, wdata, wmask, output rdata);
endinterface

// file: hw/fts_mem.sv
// storage array with registered read and per-bit write mask
`timescale 1ns/1ps
module fts_mem
   import fts_pkg::*;
#(
   parameter int AW = fts_pkg::ADDR_W,
   parameter int DW = fts_pkg::WORD_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // array port
   fts_mem_if.mem   mp
);
   logic [DW-1:0] arr [2**AW];
   logic [DW-1:0] rdata_q;
   wire  [DW-1:0] old_w  = arr[mp.raddr];
   wire           hit_w  = mp.we && (mp.waddr == mp.raddr);
   // write-first so a read right behind a write sees the new bytes
   wire  [DW-1:0] fwd_w  = (mp.wdata & mp.wmask) | (old_w & ~mp.wmask);

   always_ff @(posedge pclk) begin
      if (mp.we) begin
         arr[mp.waddr] <= (mp.wdata & mp.wmask) | (arr[mp.waddr] & ~mp.wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (mp.re) begin
         rdata_q <= hit_w ? fwd_w : old_w;
      end
   end

   assign mp.rdata = rdata_q;
endmodule // fts_mem

// file: hw/fts_ctrl.sv
// pin-level data bus and control of a flow-through burst sram
`timescale 1ns/1ps
module fts_ctrl
   import fts_pkg::*;
#(
   parameter int ADDR_W = fts_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [fts_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // sram control pins
   input  wire logic                      clock_qualifier_n,
   input  wire logic                      chip_sel1_n,
   input  wire logic                      chip_sel2,
   input  wire logic                      chip_sel3_n,
   input  wire logic                      advance_or_load,
   input  wire logic                      write_en_n,
   input  wire logic [1:0]                byte_lane_select_n,
   input  wire logic [ADDR_W-1:0]         addr,
   input  wire logic                      output_enable_n,
   input  wire logic                      burst_mode_strap,
   // data and parity lines, split into in, out, enable
   input  wire logic [fts_pkg::DATA_W-1:0] data_in,
   output logic      [fts_pkg::DATA_W-1:0] data_out,
   output logic                           data_oe_n,
   input  wire logic [fts_pkg::PAR_W-1:0]  parity_lines_in,
   output logic      [fts_pkg::PAR_W-1:0]  parity_lines_out,
   output logic                           parity_lines_oe_n
);
   import fts_pkg::*;

   localparam int BUF_W  = ADDR_W + WORD_W;
   localparam int PTR_W  = $clog2(BUF_DEPTH);

   // ****************************************
   // elaboration checks
   // ****************************************
   generate
      if (ADDR_W < CNT_W + 1 || ADDR_W > 24) begin : g_bad_aw
         $error("fts_ctrl: ADDR_W out of range");
      end
      if (BUF_DEPTH != 2) begin : g_bad_depth
         $error("fts_ctrl: buffer depth must be two");
      end
   endgenerate

   // ****************************************
   // helpers
   // ****************************************
   // burst order: xor for interleaved, add for linear; carry never leaves bit 1
   function automatic logic [CNT_W-1:0] burst_lsb(input logic [CNT_W-1:0] start,
                                                   input logic [CNT_W-1:0] step,
                                                   input logic             inter);
      burst_lsb = inter ? (start ^ step) : CNT_W'(start + step);
   endfunction

   function automatic logic [WORD_W-1:0] lane_mask(input logic [1:0] en);
      lane_mask = {en[1], en[0], {LANE_W{en[1]}}, {LANE_W{en[0]}}};
   endfunction

   // ****************************************
   // state
   // ****************************************
   fts_phase_t        phase_q, phase_d;
   logic [ADDR_W-1:0] base_q, base_d;
   logic [ADDR_W-1:0] cur_addr_q;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [1:0]        lane_q;
   logic              first_q;
   logic              mode_q;
   logic              strap_taken_q;
   logic              ctrl_en_q;
   logic [WORD_W-1:0] capture_q;
   logic [ADDR_W-1:0] buf_addr_q;
   logic [31:0]       prdata_q;

   fts_mem_if #(.AW(ADDR_W), .DW(WORD_W)) mif ();

   // ****************************************
   // pin decode
   // ****************************************
   wire              qual_w     = ~clock_qualifier_n;
   wire              chip_on_w  = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n & ctrl_en_q;
   wire              load_w     = ~advance_or_load;
   wire              active_w   = (phase_q != PH_DESEL);
   wire [CNT_W-1:0]  step_w     = CNT_W'(cnt_q + 1'b1);
   wire [ADDR_W-1:0] adv_addr_w = {base_q[ADDR_W-1:CNT_W],
                                   burst_lsb(base_q[CNT_W-1:0], step_w, mode_q)};
   wire [ADDR_W-1:0] next_addr_w = load_w ? addr : adv_addr_w;

   always_comb begin
      phase_d = phase_q;
      base_d  = base_q;
      cnt_d   = cnt_q;
      if (load_w) begin
         base_d = addr;
         cnt_d  = '0;
         if (chip_on_w) begin
            phase_d = write_en_n ? PH_READ : PH_WRITE;
         end else begin
            phase_d = PH_DESEL;
         end
      end else if (active_w) begin
         // chip enables and write enable are ignored while advancing
         cnt_d = step_w;
      end
   end

   // ****************************************
   // phase registers, all held when unqualified
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q    <= PH_DESEL;
         base_q     <= '0;
         cur_addr_q <= '0;
         cnt_q      <= '0;
         lane_q     <= '0;
         first_q    <= 1'b0;
      end else if (qual_w) begin
         phase_q    <= phase_d;
         base_q     <= base_d;
         cur_addr_q <= next_addr_w;
         cnt_q      <= cnt_d;
         lane_q     <= ~byte_lane_select_n;
         first_q    <= ~active_w & (phase_d != PH_DESEL);
      end
   end

   // strap caught once after reset release; floating reads as interleaved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q        <= MODE_RST;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         mode_q        <= burst_mode_strap;
         strap_taken_q <= 1'b1;
      end
   end

   // ****************************************
   // output drivers
   // ****************************************
   // oe pin is asynchronous, so the enable is combinational from it
   wire drive_w = ~output_enable_n & (phase_q == PH_READ) & ~first_q;
   assign data_oe_n         = ~drive_w;
   assign parity_lines_oe_n = ~drive_w;
   assign data_out          = mif.rdata[DATA_W-1:0];
   assign parity_lines_out  = mif.rdata[WORD_W-1:DATA_W];

   // ****************************************
   // input capture
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_q <= '0;
      end else if (qual_w && !drive_w) begin
         capture_q <= {parity_lines_in, data_in};
      end
   end

   // ****************************************
   // two-entry write buffer from software
   // ****************************************
   logic [BUF_W-1:0] buf_mem_q [BUF_DEPTH];
   logic [PTR_W-1:0] buf_wp_q;
   logic [PTR_W-1:0] buf_rp_q;
   logic [PTR_W:0]   buf_cnt_q;

   wire pin_we_w    = qual_w & (phase_q == PH_WRITE);
   wire buf_in_rdy  = (buf_cnt_q != (PTR_W+1)'(BUF_DEPTH));
   wire buf_out_vld = (buf_cnt_q != '0);
   // pin-side writes own the array port; software words wait
   wire buf_out_rdy = ~pin_we_w;
   wire buf_pop_w   = buf_out_vld & buf_out_rdy;

   wire acc_w       = psel & penable;
   wire wr_data_w   = acc_w & pwrite & (paddr == OFS_BUF_DATA);
   wire buf_push_w  = wr_data_w & buf_in_rdy;
   wire [BUF_W-1:0] buf_head_w = buf_mem_q[buf_rp_q];

   always_ff @(posedge pclk) begin
      if (buf_push_w) begin
         buf_mem_q[buf_wp_q] <= {buf_addr_q, pwdata[WORD_W-1:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_wp_q  <= '0;
         buf_rp_q  <= '0;
         buf_cnt_q <= '0;
      end else begin
         if (buf_push_w) begin
            buf_wp_q <= buf_wp_q + 1'b1;
         end
         if (buf_pop_w) begin
            buf_rp_q <= buf_rp_q + 1'b1;
         end
         buf_cnt_q <= buf_cnt_q + (PTR_W+1)'(buf_push_w) - (PTR_W+1)'(buf_pop_w);
      end
   end

   // ****************************************
   // array port
   // ****************************************
   assign mif.re    = qual_w & (phase_d == PH_READ);
   assign mif.raddr = next_addr_w;
   assign mif.we    = pin_we_w | buf_pop_w;
   assign mif.waddr = pin_we_w ? cur_addr_q : buf_head_w[BUF_W-1:WORD_W];
   assign mif.wdata = pin_we_w ? {parity_lines_in, data_in} : buf_head_w[WORD_W-1:0];
   assign mif.wmask = pin_we_w ? lane_mask(lane_q) : {WORD_W{1'b1}};

   fts_mem #(
      .AW (ADDR_W),
      .DW (WORD_W)
   ) u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .mp      (mif.mem)
   );

   // ****************************************
   // apb register file
   // ****************************************
   wire setup_w  = psel & ~penable;
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_st   = (paddr == OFS_STATUS);
   wire hit_cap  = (paddr == OFS_CAPTURE);
   wire hit_ba   = (paddr == OFS_BUF_ADDR);
   wire hit_bd   = (paddr == OFS_BUF_DATA);
   wire mapped_w = hit_ctrl | hit_st | hit_cap | hit_ba | hit_bd;
   wire wr_acc_w = acc_w & pwrite & pready & ~pslverr;

   wire [31:0] status_w = {25'h000_0000, buf_out_vld, cnt_q, first_q,
                           (phase_q == PH_READ), active_w, mode_q};
   wire [31:0] rd_mux_w = hit_ctrl ? {31'h0000_0000, ctrl_en_q} :
                          hit_st   ? status_w :
                          hit_cap  ? 32'(capture_q) :
                          hit_ba   ? 32'(buf_addr_q) : 32'h0000_0000;

   // a full buffer holds the access phase until a word drains
   assign pready  = ~(wr_data_w & ~buf_in_rdy);
   assign pslverr = acc_w & ~mapped_w;
   assign prdata  = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (setup_w) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux_w;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_q  <= CTRL_EN_RST;
         buf_addr_q <= '0;
      end else if (wr_acc_w) begin
         if (hit_ctrl) begin
            ctrl_en_q <= pwdata[CTRL_EN_BIT];
         end
         if (hit_ba) begin
            buf_addr_q <= pwdata[ADDR_W-1:0];
         end else if (hit_bd) begin
            buf_addr_q <= buf_addr_q + ADDR_W'(1);
         end
      end
   end
endmodule // fts_ctrl

// file: tb/fts_ctrl_sva.sv
// port-level assertions for the sram pin controller
`timescale 1ns/1ps
module fts_ctrl_sva
   import fts_pkg::*;
(
   // clock and reset
   input wire logic                       pclk,
   input wire logic                       presetn,
   // pin commands
   input wire logic                       clock_qualifier_n,
   input wire logic                       chip_sel1_n,
   input wire logic                       chip_sel2,
   input wire logic                       chip_sel3_n,
   input wire logic                       advance_or_load,
   input wire logic                       write_en_n,
   input wire logic                       output_enable_n,
   // data side
   input wire logic [fts_pkg::DATA_W-1:0] data_out,
   input wire logic                       data_oe_n,
   input wire logic [fts_pkg::PAR_W-1:0]  parity_lines_out,
   input wire logic                       parity_lines_oe_n
);
   // ****************************************
   // assertions
   // ****************************************
   wire logic q     = ~clock_qualifier_n;
   wire logic sel   = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
   wire logic ld    = q & ~advance_or_load;
   wire logic rd_ld = ld & sel & write_en_n;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_oe_off;
      output_enable_n |-> data_oe_n;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("driver on with oe high");
   property p_par_oe;
      parity_lines_oe_n == data_oe_n;
   endproperty
   a_par_oe: assert property (p_par_oe) else $error("parity enable differs");
   property p_desel;
      ld && !sel |=> data_oe_n;
   endproperty
   a_desel: assert property (p_desel) else $error("driven while deselected");
   property p_wr;
      ld && sel && !write_en_n |=> data_oe_n;
   endproperty
   a_wr: assert property (p_wr) else $error("driven in write data phase");
   property p_first;
      (ld && !sel) ##1 rd_ld |=> data_oe_n;
   endproperty
   a_first: assert property (p_first) else $error("driven right after deselect");
   property p_drive;
      rd_ld ##1 (q && advance_or_load) ##1 !output_enable_n |-> !data_oe_n;
   endproperty
   a_drive: assert property (p_drive) else $error("read burst not driven");
   // a masked edge must leave the read word alone, not only the phase
   property p_hold;
      clock_qualifier_n |=> $stable(data_out) && $stable(parity_lines_out);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved on masked edge");
   property p_stretch;
      clock_qualifier_n ##1 $stable(output_enable_n) |-> $stable(data_oe_n);
   endproperty
   a_stretch: assert property (p_stretch) else $error("enable moved in stretch");
endmodule // fts_ctrl_sva

bind fts_ctrl fts_ctrl_sva u_sva (
   .pclk              (pclk),
   .presetn           (presetn),
   .clock_qualifier_n (clock_qualifier_n),
   .chip_sel1_n       (chip_sel1_n),
   .chip_sel2         (chip_sel2),
   .chip_sel3_n       (chip_sel3_n),
   .advance_or_load   (advance_or_load),
   .write_en_n        (write_en_n),
   .output_enable_n   (output_enable_n),
   .data_out          (data_out),
   .data_oe_n         (data_oe_n),
   .parity_lines_out  (parity_lines_out),
   .parity_lines_oe_n (parity_lines_oe_n)
);

// file: tb/fts_host_model.sv
// far-side bus model: resolves the shared data and parity lines
`timescale 1ns/1ps
module fts_host_model (
   // clock
   input wire logic        pclk,
   // device side
   input wire logic [15:0] data_out,
   input wire logic        data_oe_n,
   input wire logic [1:0]  parity_lines_out,
   input wire logic        parity_lines_oe_n,
   // controller side
   input wire logic        drv_en,
   input wire logic [17:0] drv_val,
   output logic     [17:0] bus
);
   // ****************************************
   // bus resolution
   // ****************************************
   // a released line shows a moving pattern so a stale word never passes
   logic [17:0]      last_q = 18'h0_0000;
   wire logic [17:0] dev_w  = {parity_lines_out, data_out};
   wire logic [17:0] dev_on = {{2{~parity_lines_oe_n}}, {16{~data_oe_n}}};
   assign bus = (drv_en && |dev_on) ? 'x :
                (dev_on & dev_w) | (~dev_on & (drv_en ? drv_val : ~last_q));
   always_ff @(posedge pclk) begin
      last_q <= bus;
   end
endmodule // fts_host_model

// file: tb/testbench.sv
// self-checking bench for the sram pin controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
   import fts_pkg::*;
   // ****************************************
   // wiring
   // ****************************************
   // pin command: {qualifier_n, advance, write_en_n, select1_n, lanes_n}
   localparam logic [5:0] WR = 6'h00, RD = 6'h08, DS = 6'h0C, ADV = 6'h18, SUS = 6'h20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic clock_qualifier_n = 1'b0, chip_sel1_n = 1'b1, chip_sel2 = 1'b1, chip_sel3_n = 1'b0;
   logic advance_or_load = 1'b0, write_en_n = 1'b1, output_enable_n = 1'b0;
   logic burst_mode_strap = 1'b1, drv_en = 1'b0, err_q, rdoe;
   logic [1:0] byte_lane_select_n = 2'h0;
   logic [17:0] addr = 18'h0_0000, drv_val = 18'h0_0000, rd;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, data_oe_n, parity_lines_oe_n;
   wire logic [15:0] data_out;
   wire logic [1:0] parity_lines_out;
   wire logic [17:0] bus;
   wire logic [15:0] data_in = bus[15:0];
   wire logic [1:0] parity_lines_in = bus[17:16];
   int n_fail = 0;
   int tests_run = 0;
   always #4 pclk = ~pclk;
   fts_ctrl u_dut (
      .pclk (pclk), .presetn (presetn),
      .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr),
      .pwdata (pwdata), .prdata (prdata), .pready (pready), .pslverr (pslverr),
      .clock_qualifier_n (clock_qualifier_n), .chip_sel1_n (chip_sel1_n),
      .chip_sel2 (chip_sel2), .chip_sel3_n (chip_sel3_n),
      .advance_or_load (advance_or_load), .write_en_n (write_en_n),
      .byte_lane_select_n (byte_lane_select_n), .addr (addr),
      .output_enable_n (output_enable_n), .burst_mode_strap (burst_mode_strap),
      .data_in (data_in), .data_out (data_out), .data_oe_n (data_oe_n),
      .parity_lines_in (parity_lines_in), .parity_lines_out (parity_lines_out),
      .parity_lines_oe_n (parity_lines_oe_n)
   );
   fts_host_model u_host (
      .pclk (pclk), .data_out (data_out), .data_oe_n (data_oe_n),
      .parity_lines_out (parity_lines_out), .parity_lines_oe_n (parity_lines_oe_n),
      .drv_en (drv_en), .drv_val (drv_val), .bus (bus)
   );
   function automatic logic [17:0] wv(input logic [17:0] a);
      return a ^ 18'h2_A5C3;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic rst();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // one bus cycle; samples the lines at the falling edge, midway between rising edges
   task automatic pin(input logic [5:0] c, input logic [17:0] a = 18'h0_0000,
                      input logic de = 1'b0, input logic [17:0] dv = 18'h0_0000);
      {clock_qualifier_n, advance_or_load, write_en_n, chip_sel1_n, byte_lane_select_n} <= c;
      addr <= a;
      drv_en <= de;
      drv_val <= dv;
      @(negedge pclk);
      rd = bus;
      rdoe = data_oe_n;
      @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output int nw);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // the access ends at the first rising edge that sees pready high
      for (nw = 0; nw < 50; nw++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (nw == 50) begin
         n_fail++;
         summarize();
      end
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic preload(input logic [17:0] b, output int tot);
      logic [31:0] q;
      int w;
      tot = 0;
      apb(1'b1, OFS_BUF_ADDR, 32'(b), q, w);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_BUF_DATA, 32'(wv(b + 18'(i))), q, w);
         tot += w;
      end
      repeat (2) @(posedge pclk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      logic [31:0] q;
      int w;
      apb(1'b0, OFS_CTRL, 32'h0000_0000, q, w);
      `CHK("ctrl_reset", 32'h0000_0001, q)
      apb(1'b1, OFS_CTRL, 32'h0000_0000, q, w);
      apb(1'b0, OFS_CTRL, 32'h0000_0000, q, w);
      `CHK("ctrl_write", 32'h0000_0000, q)
      apb(1'b1, OFS_CTRL, 32'h0000_0001, q, w);
      apb(1'b0, 12'h0FC, 32'h0000_0000, q, w);
      `CHK("unmapped_err", 1'b1, err_q)
      // drive a known word while deselected, then freeze it with a masked edge
      pin(DS, 18'h0_0000, 1'b1, 18'h1_2345);
      pin(SUS);
      apb(1'b0, OFS_CAPTURE, 32'h0000_0000, q, w);
      `CHK("capture", 32'h0001_2345, q)
      pin(DS);
      $display("register test done");
   endtask
   // pin write burst keeps the array busy so the buffer must fill and stall
   task automatic t_buf();
      int tot;
      fork
         preload(18'h0_0040, tot);
         begin
            pin(WR, 18'h0_0101);
            for (int i = 0; i < 12; i++)
               pin(i < 11 ? ADV : DS, 18'h0_0000, 1'b1, ~wv(18'(i)));
         end
      join
      `CHK("buffer_stall", 1'b1, tot > 0)
      $display("buffer test done");
   endtask
   task automatic t_rd();
      pin(RD, 18'h0_0101);
      for (int i = 0; i < 5; i++) begin
         pin(i == 4 ? DS : RD, 18'h0_0100 | 18'(1 ^ (i % 4)));
         if (i == 0)
            `CHK("first_oe_n", 1'b1, rdoe)
         else
            `CHK("burst_write", ~wv(18'(i + 7)), rd)
      end
      $display("read test done");
   endtask
   task automatic t_lane();
      logic [17:0] e, d;
      e = wv(18'h0_0041);
      for (int i = 0; i < 2; i++) begin
         d = ~e ^ 18'(i);
         pin(i ? 6'h01 : 6'h02, 18'h0_0041);
         pin(RD, 18'h0_0041, 1'b1, d);
         e = i ? {d[17], e[16], d[15:8], e[7:0]} : {e[17], d[16], e[15:8], d[7:0]};
         pin(DS);
         `CHK("lane_write", e, rd)
         `CHK("read_driven", 1'b0, rdoe)
      end
      output_enable_n <= 1'b1;
      pin(6'h03, 18'h0_0090);
      pin(RD, 18'h0_0041, 1'b1, e);
      pin(DS);
      `CHK("oe_high", 1'b1, rdoe)
      output_enable_n <= 1'b0;
      $display("lane test done");
   endtask
   task automatic t_burst(input logic s);
      int ix[7] = '{0, 1, 2, 2, 2, 3, 4};
      logic [5:0] cm[7] = '{ADV, ADV, SUS, SUS, ADV, ADV, DS};
      int tot;
      logic [1:0] k;
      logic [31:0] q;
      // strap is only caught at the first edge after reset release
      burst_mode_strap <= s;
      rst();
      apb(1'b0, OFS_STATUS, 32'h0000_0000, q, tot);
      `CHK("mode", s, q[ST_MODE_BIT])
      preload(18'h0_0080, tot);
      pin(6'h03, 18'h0_0090);
      pin(RD, 18'h0_0081, 1'b1);
      for (int c = 0; c < 7; c++) begin
         pin(cm[c]);
         k = s ? 2'b01 ^ 2'(ix[c]) : 2'b01 + 2'(ix[c]);
         `CHK("burst_read", wv({16'h0020, k}), rd)
      end
      $display("burst test done");
   endtask
   initial begin
      rst();
      t_regs();
      t_buf();
      t_rd();
      t_lane();
      t_burst(1'b1);
      t_burst(1'b0);
      summarize();
   end
endmodule // testbench
